// ### verilog/clpm_top.sv
// Clock divider, timed write window, Idle/Stop/Sleep sequencing and watchdog count
//
// What this block does
// - Upper clock-divider bit always reads zero; divided CPU clock mode never entered.
// - With switch-back set, integrated peripheral activity restores full-speed clocking.
// - System clock is the oscillator divided per the 4-bit divider code table.
// - After reset or Sleep wake, wait 64/128/256/512 oscillator cycles for regulator.
// - Clock select resets to 0x98 and is writable only inside the timed window.
// - Wake mask holds seven source enables, bit 5 unused, resets all ones, protected.
// - Stop wake always fires on the source edge, whatever its interrupt trigger type.
// - Stop wake gating ignores interrupt enable; a disabled source just resumes the CPU.
// - A valid wake restarts the oscillator; after Stop the CPU resumes on its first clock edge.
// - In Stop only pins and unclocked sources may wake; clocked peripherals cannot.
// - Idle stops CPU and integrated peripheral clocks; external peripherals keep running.
// - Idle ends on any enabled interrupt; idle bit clears by hardware.
// - Stop halts every clock; oscillator shuts down on its last edge, no runt pulse.
// - Stop exit needs only the mask bit, async wakes none; pins active low, peripheral flags high.
// - On Stop entry the stop bit is cleared by hardware.
// - Stop plus sleep enters Sleep: also regulator off, back on at wake.
// - Oscillator runs in every mode but Stop and Sleep; calibrated default 16 MHz.
// - A 30-bit watchdog counter runs on the CPU clock and halts with it.
// - Writing 0xAA then 0x55 opens a 256-cycle window for protected writes.
// - Power control holds sleep, stop, idle at bits 2..0, write-only, reset zero.
`timescale 1ns/1ps
`default_nettype none
`include "clpm_cfg.svh"

module clpm_top (
    input  wire logic        clk,
    input  wire logic        reset_pin,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [7:0]  wake_src,
    input  wire logic [7:0]  wake_int_en,
    input  wire logic [3:0]  async_wake,
    input  wire logic        irq_pending,
    input  wire logic        periph_activity,
    input  wire logic        wdt_clear,
    output logic             sys_clk_tick,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             osc_enable,
    output logic             regulator_on,
    output logic             cpu_resume,
    output logic             idle_active,
    output logic             stop_active,
    output logic             sleep_guard,
    output logic             window_open,
    output logic      [29:0] wdt_count
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    localparam int SLEEP_NOP_CYCLES = `CLPM_SLEEP_NOP_CYCLES;
    localparam int OSC_CAL_HZ       = `CLPM_OSC_CAL_HZ;

    function automatic logic [10:0] div_of(input logic [3:0] code);
        logic [10:0] d;
        d = 11'h001;
        if (code == 4'h0)
            d = 11'h001;
        else if (code < 4'h8)
            d = {6'h00, code, 1'b0};
        else if (code == 4'h8)
            d = 11'h00F;
        else if (code == 4'h9)
            d = 11'h010;
        else
            d = 11'h020 << (code - 4'hA);
        return d;
    endfunction

    function automatic logic [9:0] settle_of(input logic [1:0] code);
        return `CLPM_SETTLE_BASE << code;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0]              system_clock_select_q;
    logic [7:0]              wake_source_mask_q;
    logic                    swb_q;
    logic                    key_armed_q;
    logic [8:0]              window_q;
    clpm_pkg::clpm_mode_type mode_q;
    logic                    sleep_q;
    logic                    pend_idle_q;
    logic                    pend_stop_q;
    logic                    pend_sleep_q;
    logic                    switched_back_q;
    logic [10:0]             div_cnt_q;
    logic [10:0]             div_cur_q;
    logic [9:0]              settle_q;
    logic [9:0]              guard_q;
    logic [7:0]              src_s1_q;
    logic [7:0]              src_s2_q;
    logic [7:0]              src_prev_q;
    logic [3:0]              aw_s1_q;
    logic [3:0]              aw_s2_q;
    logic [3:0]              aw_prev_q;

    logic wr_power_control_reg;
    logic wr_timed;
    logic wr_prot_ok;
    logic tick;
    logic stop_wake;
    logic idle_wake;

    assign wr_power_control_reg    = sfr_wr && (sfr_addr == `CLPM_ADDR_POWER_CONTROL_REG);
    assign wr_timed   = sfr_wr && (sfr_addr == `CLPM_ADDR_TIMED);
    assign wr_prot_ok = sfr_wr && (window_q != 9'h000);
    assign tick       = osc_enable && (div_cnt_q == div_cur_q - 11'h001);

    // Timed window counts system clock periods, so it freezes while the divider is
    // stopped; software should close it before entering a low-power mode
    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin) begin
            key_armed_q <= 1'b0;
            window_q    <= 9'h000;
        end else if (wr_timed) begin
            key_armed_q <= (sfr_wdata == `CLPM_KEY_FIRST);
            if (key_armed_q && sfr_wdata == `CLPM_KEY_SECOND)
                window_q <= `CLPM_WINDOW_CYCLES;
            else if (sfr_wdata == `CLPM_KEY_CLOSE)
                window_q <= 9'h000;
        end else if (sfr_wr) begin
            key_armed_q <= 1'b0;
            if (tick && window_q != 9'h000)
                window_q <= window_q - 9'h001;
        end else if (tick && window_q != 9'h000) begin
            window_q <= window_q - 9'h001;
        end
    end

    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin) begin
            system_clock_select_q  <= `CLPM_SYSTEM_CLOCK_SELECT_RESET;
            wake_source_mask_q <= `CLPM_WAKE_SOURCE_MASK_RESET;
        end else if (wr_prot_ok) begin
            if (sfr_addr == `CLPM_ADDR_SYSTEM_CLOCK_SELECT)
                system_clock_select_q <= {sfr_wdata[7:2], 2'b00};
            if (sfr_addr == `CLPM_ADDR_WAKE_SOURCE_MASK)
                wake_source_mask_q <= (sfr_wdata & `CLPM_WAKE_SOURCE_MASK_USED) | ~`CLPM_WAKE_SOURCE_MASK_USED;
        end
    end

    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin)
            swb_q <= 1'(`CLPM_PMR_RESET >> `CLPM_PMR_SWB);
        else if (sfr_wr && sfr_addr == `CLPM_ADDR_PMR)
            swb_q <= sfr_wdata[`CLPM_PMR_SWB];
    end

    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin) begin
            sfr_rdata <= 8'h00;
        end else begin
            case (sfr_addr)
                `CLPM_ADDR_SYSTEM_CLOCK_SELECT:  sfr_rdata <= system_clock_select_q;
                `CLPM_ADDR_WAKE_SOURCE_MASK: sfr_rdata <= wake_source_mask_q;
                `CLPM_ADDR_PMR:    sfr_rdata <= {1'b0, 1'b1, swb_q, 5'h00};
                `CLPM_ADDR_TIMED:  sfr_rdata <= {7'h00, window_q != 9'h000};
                default:           sfr_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System clock divider

    // Switch-back latches on integrated activity and releases on the next divider write
    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin)
            switched_back_q <= 1'b0;
        else if (swb_q && periph_activity && mode_q == clpm_pkg::MODE_RUN)
            switched_back_q <= 1'b1;
        else if (wr_prot_ok && sfr_addr == `CLPM_ADDR_SYSTEM_CLOCK_SELECT)
            switched_back_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin) begin
            div_cnt_q <= 11'h000;
            div_cur_q <= 11'h010;
        end else if (!osc_enable) begin
            div_cnt_q <= 11'h000;
        end else if (tick) begin
            div_cnt_q <= 11'h000;
            // New ratio loads only at a period boundary
            div_cur_q <= switched_back_q ? 11'h001 : div_of(system_clock_select_q[7:4]);
        end else begin
            div_cnt_q <= div_cnt_q + 11'h001;
        end
    end

    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin) begin
            sys_clk_tick  <= 1'b0;
            cpu_clk_en    <= 1'b0;
            periph_clk_en <= 1'b0;
        end else begin
            sys_clk_tick  <= osc_enable && tick;
            cpu_clk_en    <= osc_enable && tick && mode_q == clpm_pkg::MODE_RUN
                             && !pend_idle_q && !pend_stop_q;
            periph_clk_en <= osc_enable && tick && mode_q == clpm_pkg::MODE_RUN
                             && !pend_idle_q && !pend_stop_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake sources

    // Two-flop synchroniser; only the second stage feeds the edge detectors
    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin) begin
            src_s1_q   <= 8'h03;
            src_s2_q   <= 8'h03;
            src_prev_q <= 8'h03;
            aw_s1_q    <= 4'h0;
            aw_s2_q    <= 4'h0;
            aw_prev_q  <= 4'h0;
        end else begin
            src_s1_q   <= wake_src;
            src_s2_q   <= src_s1_q;
            src_prev_q <= src_s2_q;
            aw_s1_q    <= async_wake;
            aw_s2_q    <= aw_s1_q;
            aw_prev_q  <= aw_s2_q;
        end
    end

    logic [7:0] act_now;
    logic [7:0] act_prev;
    // Pins 1..0 assert low, peripheral flags assert high
    assign act_now   = src_s2_q ^ 8'h03;
    assign act_prev  = src_prev_q ^ 8'h03;
    // Edge only, and no interrupt enable here: a masked-off interrupt still wakes
    assign stop_wake = |(act_now & ~act_prev & wake_source_mask_q & `CLPM_WAKE_SOURCE_MASK_USED)
                       || |(aw_s2_q & ~aw_prev_q);
    assign idle_wake = irq_pending || |(act_now & wake_int_en);

    ////////////////////////////////////////////////////////////////////////////
    // Power mode sequencer

    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin) begin
            mode_q       <= clpm_pkg::MODE_SETTLE;
            settle_q     <= settle_of(2'(`CLPM_SYSTEM_CLOCK_SELECT_RESET >> `CLPM_SYSTEM_CLOCK_SELECT_SETTLE_LSB));
            sleep_q      <= 1'b0;
            pend_idle_q  <= 1'b0;
            pend_stop_q  <= 1'b0;
            pend_sleep_q <= 1'b0;
            cpu_resume   <= 1'b0;
            osc_enable   <= 1'b1;
            regulator_on <= 1'b1;
        end else begin
            cpu_resume <= 1'b0;
            case (mode_q)
                clpm_pkg::MODE_RUN: begin
                    if (wr_power_control_reg && sfr_wdata[`CLPM_POWER_CONTROL_REG_STOP]) begin
                        pend_stop_q  <= 1'b1;
                        pend_sleep_q <= sfr_wdata[`CLPM_POWER_CONTROL_REG_SLEEP];
                    end else if (wr_power_control_reg && sfr_wdata[`CLPM_POWER_CONTROL_REG_IDLE]) begin
                        pend_idle_q <= 1'b1;
                    end
                    // Enter only at a divider boundary so the last clock period is whole
                    if (tick && pend_stop_q) begin
                        mode_q       <= clpm_pkg::MODE_STOP;
                        osc_enable   <= 1'b0;
                        regulator_on <= !pend_sleep_q;
                        sleep_q      <= pend_sleep_q;
                        pend_stop_q  <= 1'b0;
                        pend_sleep_q <= 1'b0;
                    end else if (tick && pend_idle_q) begin
                        mode_q      <= clpm_pkg::MODE_IDLE;
                        pend_idle_q <= 1'b0;
                    end
                end
                clpm_pkg::MODE_IDLE: begin
                    if (idle_wake) begin
                        mode_q     <= clpm_pkg::MODE_RUN;
                        cpu_resume <= 1'b1;
                    end
                end
                clpm_pkg::MODE_STOP: begin
                    if (stop_wake) begin
                        osc_enable   <= 1'b1;
                        regulator_on <= 1'b1;
                        sleep_q      <= 1'b0;
                        if (sleep_q) begin
                            mode_q   <= clpm_pkg::MODE_SETTLE;
                            settle_q <= settle_of(system_clock_select_q[3:2]);
                        end else begin
                            mode_q     <= clpm_pkg::MODE_RUN;
                            cpu_resume <= 1'b1;
                        end
                    end
                end
                clpm_pkg::MODE_SETTLE: begin
                    if (settle_q <= 10'h001) begin
                        mode_q     <= clpm_pkg::MODE_RUN;
                        cpu_resume <= 1'b1;
                    end else begin
                        settle_q <= settle_q - 10'h001;
                    end
                end
                default: begin
                    mode_q <= clpm_pkg::MODE_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin) begin
            idle_active <= 1'b0;
            stop_active <= 1'b0;
        end else begin
            idle_active <= mode_q == clpm_pkg::MODE_IDLE;
            stop_active <= mode_q == clpm_pkg::MODE_STOP;
        end
    end

    // Flags the no-operation interval software owes after a Sleep wake
    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin) begin
            guard_q     <= 10'h000;
            sleep_guard <= 1'b0;
        end else begin
            if (mode_q == clpm_pkg::MODE_STOP && stop_wake && sleep_q)
                guard_q <= 10'(SLEEP_NOP_CYCLES);
            else if (guard_q != 10'h000)
                guard_q <= guard_q - 10'h001;
            sleep_guard <= guard_q != 10'h000;
        end
    end

    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin)
            window_open <= 1'b0;
        else
            window_open <= window_q != 9'h000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog count

    // Shares the CPU clock, so it freezes in Idle, Stop and Sleep
    always_ff @(posedge clk or negedge reset_pin) begin
        if (!reset_pin)
            wdt_count <= 30'h0000_0000;
        else if (wdt_clear)
            wdt_count <= 30'h0000_0000;
        else if (cpu_clk_en)
            wdt_count <= wdt_count + 30'h0000_0001;
    end

endmodule // clpm_top
`default_nettype wire

// ### verilog/clpm_cfg.svh
// Offsets, field positions, reset values and timing counts of the clock and power block
`ifndef CLPM_CFG_SVH
`define CLPM_CFG_SVH

`define CLPM_ADDR_POWER_CONTROL_REG        8'h87
`define CLPM_ADDR_SYSTEM_CLOCK_SELECT       8'h8F
`define CLPM_ADDR_WAKE_SOURCE_MASK      8'h9F
`define CLPM_ADDR_PMR         8'hC4
`define CLPM_ADDR_TIMED       8'hC9

`define CLPM_POWER_CONTROL_REG_IDLE        0
`define CLPM_POWER_CONTROL_REG_STOP        1
`define CLPM_POWER_CONTROL_REG_SLEEP       2
`define CLPM_PMR_SWB          5
`define CLPM_PMR_CD0          6
`define CLPM_PMR_CD1          7
`define CLPM_SYSTEM_CLOCK_SELECT_DIV_LSB    4
`define CLPM_SYSTEM_CLOCK_SELECT_SETTLE_LSB 2

`define CLPM_SYSTEM_CLOCK_SELECT_RESET      8'h98
`define CLPM_WAKE_SOURCE_MASK_RESET     8'hFF
`define CLPM_WAKE_SOURCE_MASK_USED      8'hDF
`define CLPM_PMR_RESET        8'h40

`define CLPM_KEY_FIRST        8'hAA
`define CLPM_KEY_SECOND       8'h55
`define CLPM_KEY_CLOSE        8'h00

`define CLPM_WINDOW_CYCLES    9'h100
`define CLPM_SETTLE_BASE      10'h040
`define CLPM_CLK_PERIOD_NS    25
`define CLPM_SLEEP_NOP_NS     20000
`define CLPM_SLEEP_NOP_CYCLES ((`CLPM_SLEEP_NOP_NS + `CLPM_CLK_PERIOD_NS - 1) / `CLPM_CLK_PERIOD_NS)
`define CLPM_OSC_CAL_HZ       16000000

`endif

// ### verilog/clpm_pkg.sv
// Types shared by the clock and power block
`default_nettype none
package clpm_pkg;
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_IDLE,
        MODE_STOP,
        MODE_SETTLE
    } clpm_mode_type;
endpackage
`default_nettype wire

// ### tb/clpm_top_properties.sv
// Port-level checks of the clock and power block
`timescale 1ns/1ps
`default_nettype none
module clpm_top_properties (
    input wire logic        clk,
    input wire logic        reset_pin,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic [7:0]  sfr_rdata,
    input wire logic [3:0]  async_wake,
    input wire logic        irq_pending,
    input wire logic        wdt_clear,
    input wire logic        sys_clk_tick,
    input wire logic        cpu_clk_en,
    input wire logic        osc_enable,
    input wire logic        regulator_on,
    input wire logic        cpu_resume,
    input wire logic        idle_active,
    input wire logic        stop_active,
    input wire logic        window_open,
    input wire logic [29:0] wdt_count
);
    logic key_w;
    logic low_w;
    assign key_w = sfr_wr && sfr_addr == 8'hC9 && sfr_wdata == 8'h55;
    assign low_w = idle_active || stop_active;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_pin);
    ////////////////////////////////////////////////////////////////////////
    sequence s_wake_edge;
        stop_active && ($rose(async_wake[0]) || $rose(async_wake[1]));
    endsequence
    sequence s_keys_done;
        $past(key_w, 1) || $past(key_w, 2) || $past(key_w, 3);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_cpu_on_tick: assert property (cpu_clk_en |-> sys_clk_tick)
        else $error("cpu enable outside a tick");
    a_idle_cpu_off: assert property (idle_active && !cpu_resume |-> !cpu_clk_en)
        else $error("cpu clock runs in idle");
    a_osc_off_quiet: assert property (!osc_enable && !$past(osc_enable) |-> !sys_clk_tick)
        else $error("tick while oscillator off");
    a_async_wake_osc: assert property (s_wake_edge |-> ##[1:4] osc_enable)
        else $error("oscillator not restarted by wake");
    a_idle_irq_wake: assert property ($rose(irq_pending) && idle_active |-> ##[1:2] cpu_resume)
        else $error("idle not ended by interrupt");
    a_reg_off_sleep: assert property ($fell(regulator_on) |-> ##[0:1] stop_active)
        else $error("regulator off outside sleep");
    a_wdt_frozen_low: assert property (low_w && $past(low_w) && $past(low_w, 2) && !wdt_clear
        && !$past(wdt_clear) |-> $stable(wdt_count))
        else $error("watchdog counts without cpu clock");
    a_pwr_reads_zero: assert property ($past(sfr_addr) == 8'h87 |-> sfr_rdata == 8'h00)
        else $error("power control read not zero");
    a_mode_fixed_bits: assert property ($past(sfr_addr) == 8'hC4 |-> sfr_rdata[7:6] == 2'b01)
        else $error("divider control bits wrong");
    a_sel_low_zero: assert property ($past(sfr_addr) == 8'h8F |-> sfr_rdata[1:0] == 2'b00)
        else $error("clock select low bits set");
    a_mask_bit_set: assert property ($past(sfr_addr) == 8'h9F |-> sfr_rdata[5])
        else $error("wake mask bit five clear");
    a_window_keys: assert property ($rose(window_open) |-> s_keys_done)
        else $error("window opened without key pair");
endmodule // clpm_top_properties
bind clpm_top clpm_top_properties clpm_top_properties_inst (.clk(clk), .reset_pin(reset_pin), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .async_wake(async_wake),
    .irq_pending(irq_pending), .wdt_clear(wdt_clear), .sys_clk_tick(sys_clk_tick), .cpu_clk_en(cpu_clk_en),
    .osc_enable(osc_enable), .regulator_on(regulator_on), .cpu_resume(cpu_resume),
    .idle_active(idle_active), .stop_active(stop_active), .window_open(window_open), .wdt_count(wdt_count));
`default_nettype wire

// ### tb/clpm_src_model.sv
// Wake and interrupt sources facing the clock and power block
`timescale 1ns/1ps
`default_nettype none
module clpm_src_model (
    input  wire logic       clk,
    output var  logic [7:0] wake_src,
    output var  logic [3:0] async_wake,
    output var  logic       irq_pending,
    output var  logic       periph_activity
);
    // Pins rest high, peripheral flags rest low
    localparam logic [7:0] REST = 8'h03;
    initial begin
        wake_src = REST;
        async_wake = 4'h0;
        irq_pending = 1'b0;
        periph_activity = 1'b0;
    end
    task automatic src(input int i, input bit act);
        @(posedge clk);
        wake_src[i] <= act ? ~REST[i] : REST[i];
    endtask
    task automatic aw(input int i, input bit v);
        @(posedge clk);
        async_wake[i] <= v;
    endtask
    task automatic irq(input bit v);
        @(posedge clk);
        irq_pending <= v;
    endtask
    task automatic act(input bit v);
        @(posedge clk);
        periph_activity <= v;
    endtask
endmodule // clpm_src_model
`default_nettype wire

// ### tb/clpm_top_tb.sv
// Self-checking bench of the clock and power block
`timescale 1ns/1ps
`default_nettype none
module clpm_top_tb;
    localparam logic [7:0] A_PWR = 8'h87, A_SEL = 8'h8F, A_MSK = 8'h9F, A_MOD = 8'hC4, A_KEY = 8'hC9;
    logic        clk, reset_pin, sfr_wr, wdt_clear, rd_req, rd_pend;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, wake_src, wake_int_en, v;
    logic [3:0]  async_wake;
    logic        irq_pending, periph_activity, sys_clk_tick, cpu_clk_en, periph_clk_en;
    logic        osc_enable, regulator_on, cpu_resume, idle_active, stop_active, sleep_guard, window_open;
    logic [29:0] wdt_count, w;
    logic [7:0]  exp_q[$];
    int          failures, n_tests, i, n;
    clpm_top clpm_top_inst (.clk(clk), .reset_pin(reset_pin), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .wake_src(wake_src), .wake_int_en(wake_int_en),
        .async_wake(async_wake), .irq_pending(irq_pending), .periph_activity(periph_activity),
        .wdt_clear(wdt_clear), .sys_clk_tick(sys_clk_tick), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .osc_enable(osc_enable), .regulator_on(regulator_on),
        .cpu_resume(cpu_resume), .idle_active(idle_active), .stop_active(stop_active),
        .sleep_guard(sleep_guard), .window_open(window_open), .wdt_count(wdt_count));
    clpm_src_model clpm_src_model_inst (.clk(clk), .wake_src(wake_src), .async_wake(async_wake),
        .irq_pending(irq_pending), .periph_activity(periph_activity));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        sfr_addr <= a;
        rd_req <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_req <= 1'b0;
    endtask
    task automatic open_win();
        wr(A_KEY, 8'hAA);
        wr(A_KEY, 8'h55);
    endtask
    task automatic tick_gap(output int k);
        k = 0;
        do begin @(negedge clk); k++; end while (sys_clk_tick !== 1'b1 && k < 3000);
        k = 0;
        do begin @(negedge clk); k++; end while (sys_clk_tick !== 1'b1 && k < 3000);
    endtask
    task automatic wait_resume(output int k);
        k = 0;
        do begin @(negedge clk); k++; end while (cpu_resume !== 1'b1 && k < 1500);
    endtask
    task automatic wait_low();
        for (int k = 0; k < 60 && stop_active !== 1'b1 && idle_active !== 1'b1; k++) @(negedge clk);
    endtask
    function automatic int divisor(input logic [3:0] c);
        if (c == 4'h0) return 1;
        if (c <= 4'h7) return 2 * c;
        if (c == 4'h8) return 15;
        return 16 << (c - 4'h9);
    endfunction
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Read data stands one cycle after the address, so notes lag one edge
    always @(posedge clk) begin
        if (rd_pend) chk(sfr_rdata, exp_q.pop_front(), "read");
        rd_pend <= rd_req;
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #2000000;
        failures++;
        end_sim();
    end
    initial begin
        reset_pin = 0; sfr_wr = 0; sfr_addr = 0; sfr_wdata = 0; wake_int_en = 0;
        wdt_clear = 0; rd_req = 0; rd_pend = 0; failures = 0; n_tests = 0;
        void'($urandom(32'h266f));
        repeat (2) @(posedge clk);
        reset_pin <= 1'b1;
        wait_resume(n);
        chk(n >= 256 && n <= 258, 1, "reset settle");
        rd(A_SEL, 8'h98);
        rd(A_MSK, 8'hFF);
        rd(A_MOD, 8'h40);
        rd(A_PWR, 8'h00);
        rd(8'h10, 8'h00);
        wr(A_SEL, 8'h00);
        wr(A_MSK, 8'h00);
        wr(A_KEY, 8'hAA);
        wr(A_MSK, 8'h00);
        wr(A_KEY, 8'h55);
        rd(A_SEL, 8'h98);
        rd(A_MSK, 8'hFF);
        for (i = 0; i < 16; i++) begin
            v = {i[3:0], 4'($urandom())};
            open_win();
            rd(A_KEY, 8'h01);
            wr(A_SEL, v);
            rd(A_SEL, v & 8'hFC);
            tick_gap(n);
            tick_gap(n);
            chk(n, divisor(i[3:0]), "divide");
        end
        // Fast clock before low-power entry keeps the wake latencies short
        open_win();
        v = {4'h0, 2'($urandom()), 2'b00};
        wr(A_SEL, v);
        tick_gap(n);
        chk(n, 1, "fast clock");
        n = $urandom();
        wr(A_MSK, n[7:0]);
        rd(A_MSK, n[7:0] | 8'h20);
        wr(A_MSK, 8'hFB);
        rd(A_MSK, 8'hFB);
        wr(A_KEY, 8'h00);
        rd(A_KEY, 8'h00);
        wr(A_SEL, 8'h90);
        rd(A_SEL, v);
        clpm_src_model_inst.src(3, 1'b1);
        wr(A_PWR, 8'h02);
        wait_low();
        repeat (8) @(negedge clk);
        chk(stop_active, 1, "level no wake");
        clpm_src_model_inst.src(3, 1'b0);
        clpm_src_model_inst.src(3, 1'b1);
        repeat (6) @(negedge clk);
        chk(stop_active, 0, "edge wake");
        clpm_src_model_inst.src(3, 1'b0);
        for (i = 0; i < 8; i++) if (i != 5) begin
            wake_int_en <= 8'($urandom());
            wr(A_PWR, 8'h02);
            wait_low();
            chk(osc_enable, 0, "osc off");
            clpm_src_model_inst.src(i, 1'b1);
            repeat (6) @(negedge clk);
            chk(stop_active, i == 2, "stop exit");
            clpm_src_model_inst.src(i, 1'b0);
            if (i == 2) begin
                clpm_src_model_inst.aw(1, 1'b1);
                repeat (6) @(negedge clk);
                chk({stop_active, osc_enable}, 2'b01, "async exit");
                clpm_src_model_inst.aw(1, 1'b0);
            end
        end
        @(negedge clk) w = wdt_count;
        repeat (10) @(negedge clk);
        chk(wdt_count - w, 30'd10, "wdt runs");
        wr(A_PWR, 8'h01);
        wait_low();
        w = wdt_count;
        repeat (20) @(negedge clk);
        chk({idle_active, osc_enable, cpu_clk_en, periph_clk_en}, 4'b1100, "idle");
        chk(wdt_count, w, "wdt frozen");
        clpm_src_model_inst.irq(1'b1);
        wait_resume(n);
        chk(n <= 3, 1, "idle wake");
        clpm_src_model_inst.irq(1'b0);
        @(negedge clk) chk(idle_active, 0, "idle cleared");
        @(posedge clk);
        wdt_clear <= 1'b1;
        @(posedge clk);
        wdt_clear <= 1'b0;
        @(negedge clk);
        chk(wdt_count < 4, 1, "wdt clear");
        wr(A_PWR, 8'h06);
        wait_low();
        chk({regulator_on, osc_enable}, 2'b00, "sleep");
        clpm_src_model_inst.aw(0, 1'b1);
        wait_resume(n);
        chk(n >= (64 << v[3:2]) && n <= (64 << v[3:2]) + 5, 1, "sleep settle");
        chk({regulator_on, sleep_guard}, 2'b11, "sleep exit");
        clpm_src_model_inst.aw(0, 1'b0);
        open_win();
        wr(A_SEL, 8'h90);
        wr(A_MOD, 8'h20);
        rd(A_MOD, 8'h60);
        clpm_src_model_inst.act(1'b1);
        tick_gap(n);
        chk(n, 1, "switch back");
        clpm_src_model_inst.act(1'b0);
        end_sim();
    end
endmodule // clpm_top_tb
`default_nettype wire
